// *** hdl/cmbc_sched_end.sv ***
`timescale 1ns/10ps
module cmbc_fifo #(
   parameter int WIDTH = cmbc_pkg::DATA_W,
   parameter int DEPTH = cmbc_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic [$clog2(DEPTH):0] level,
   // Draining side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   // Whole state of the FIFO
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage words
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } cmbc_fifo_state_type;

   cmbc_fifo_state_type state;
   cmbc_fifo_state_type next_state;
   logic                push;
   logic                pop;

   // Pointer step with wrap at depth
   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : step

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;

   // Next pointers, count and storage
   always_comb begin
      next_state = state;
      if (push) begin
         next_state.mem[state.wr_ptr] = in_data;
         next_state.wr_ptr            = step(state.wr_ptr);
      end
      if (pop) begin
         next_state.rd_ptr = step(state.rd_ptr);
      end
      if (push && !pop) begin
         next_state.count = state.count + 1'b1;
      end else if (pop && !push) begin
         next_state.count = state.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign in_ready  = (state.count != (AW + 1)'(DEPTH));
   assign out_valid = (state.count != '0);
   assign out_data  = state.mem[state.rd_ptr];
   assign level     = state.count;
endmodule : cmbc_fifo

module cmbc_sched_end #(
   parameter int N_REQ = 2
) (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        reset,
   // Link to memory
   cmbc_link_if.sched                       link,
   // Requesters, index 0 has highest priority
   input  wire logic [N_REQ-1:0]            req_valid,
   input  wire logic [N_REQ-1:0]            req_write,
   input  wire logic [N_REQ-1:0][cmbc_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [N_REQ-1:0][cmbc_pkg::DATA_W-1:0] req_data,
   output logic [N_REQ-1:0]                 req_ready,
   // Tags on acceptance
   output logic                             done_valid,
   output logic [((N_REQ > 1) ? $clog2(N_REQ) : 1)-1:0] done_src,
   output logic                             done_write,
   output logic [cmbc_pkg::ADDR_W-1:0]      done_addr
);
   localparam int SRC_W = (N_REQ > 1) ? $clog2(N_REQ) : 1;
   localparam int HN    = cmbc_pkg::HOPPER_N;
   localparam int ACC   = cmbc_pkg::ACCEPT_CYC;
   localparam int LW    = $clog2(cmbc_pkg::FIFO_DEPTH) + 1;

   // Whole state of the scheduler
   typedef struct packed {
      logic [3:0]                            minor;     // Phase count
      logic                                  go;
      logic                                  write;
      logic [cmbc_pkg::ADDR_W-1:0]           addr;
      logic [ACC:0]                          pipe_v;    // In flight
      logic [ACC:0][1:0]                     pipe_idx;
      logic [HN-1:0]                         hop_v;     // Hopper
      logic [HN-1:0]                         hop_wait;
      logic [HN-1:0]                         hop_write;
      logic [HN-1:0][SRC_W-1:0]              hop_src;
      logic [HN-1:0][cmbc_pkg::ADDR_W-1:0]   hop_addr;
      logic [HN-1:0][cmbc_pkg::DATA_W-1:0]   hop_data;
      logic [N_REQ-1:0]                      req_ready;
      logic                                  done_valid;
      logic [SRC_W-1:0]                      done_src;
      logic                                  done_write;
      logic [cmbc_pkg::ADDR_W-1:0]           done_addr;
      logic                                  push_v;    // To FIFO
      logic [cmbc_pkg::DATA_W-1:0]           push_data;
   } cmbc_sched_state_type;

   cmbc_sched_state_type state;
   cmbc_sched_state_type next_state;
   logic                 fifo_in_ready;  // FIFO room
   logic [LW-1:0]        fifo_level;     // FIFO fill

   // Write word buffer toward memory
   cmbc_fifo #(
      .WIDTH (cmbc_pkg::DATA_W),
      .DEPTH (cmbc_pkg::FIFO_DEPTH)
   ) u_wfifo (
      .mclk      (mclk),
      .reset     (reset),
      .in_valid  (state.push_v),
      .in_data   (state.push_data),
      .in_ready  (fifo_in_ready),
      .level     (fifo_level),
      .out_valid (link.wdata_valid),
      .out_data  (link.wdata),
      .out_ready (link.wdata_ready)
   );

   // Accept check, hopper and issue choice
   always_comb begin : comb_proc
      logic space_ok;
      int   pick;
      int   slot;
      int   req;
      space_ok = fifo_in_ready && (fifo_level
                 <= LW'(cmbc_pkg::FIFO_DEPTH - HN));
      pick     = -1;
      slot     = -1;
      req      = -1;
      next_state = state;
      next_state.go         = 1'b0;
      next_state.req_ready  = '0;
      next_state.done_valid = 1'b0;
      next_state.push_v     = 1'b0;
      next_state.minor      = (state.minor == 4'(cmbc_pkg::MINOR_CYC - 1))
                              ? 4'h0 : state.minor + 4'h1;
      next_state.pipe_v     = {state.pipe_v[ACC-1:0], 1'b0};
      next_state.pipe_idx   = {state.pipe_idx[ACC-1:0], 2'h0};
      // Accept expected exactly at the 200 ns point
      if (state.pipe_v[ACC]) begin
         slot = int'(state.pipe_idx[ACC]);
         if (link.accept) begin
            next_state.hop_v[slot] = 1'b0;
            next_state.done_valid  = 1'b1;
            next_state.done_src    = state.hop_src[slot];
            next_state.done_write  = state.hop_write[slot];
            next_state.done_addr   = state.hop_addr[slot];
            next_state.push_v      = state.hop_write[slot];
            next_state.push_data   = state.hop_data[slot];
         end else begin
            next_state.hop_wait[slot] = 1'b1;
         end
      end
      // One issue per minor cycle
      if (state.minor == 4'h0) begin
         for (int i = 0; i < HN; i++) begin
            if (pick < 0 && state.hop_v[i] && state.hop_wait[i]
                && (!state.hop_write[i] || space_ok)) begin
               pick = i;
            end
         end
         if (pick < 0) begin
            for (int i = 0; i < HN; i++) begin
               if (slot < 0 && !state.hop_v[i]) begin
                  slot = i;
               end
            end
            for (int r = 0; r < N_REQ; r++) begin
               if (req < 0 && req_valid[r]
                   && (!req_write[r] || space_ok)) begin
                  req = r;
               end
            end
            if (slot >= 0 && req >= 0 && !state.pipe_v[ACC]) begin
               pick = slot;
               next_state.hop_v[slot]     = 1'b1;
               next_state.hop_write[slot] = req_write[req];
               next_state.hop_src[slot]   = SRC_W'(req);
               next_state.hop_addr[slot]  = req_addr[req];
               next_state.hop_data[slot]  = req_data[req];
               next_state.req_ready[req]  = 1'b1;
            end
         end
         if (pick >= 0) begin
            next_state.hop_wait[pick] = 1'b0;
            next_state.go             = 1'b1;
            next_state.write          = next_state.hop_write[pick];
            next_state.addr           = next_state.hop_addr[pick];
            next_state.pipe_v[0]      = 1'b1;
            next_state.pipe_idx[0]    = 2'(pick);
         end
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign link.go    = state.go;
   assign link.write = state.write;
   assign link.addr  = state.addr;
   assign req_ready  = state.req_ready;
   assign done_valid = state.done_valid;
   assign done_src   = state.done_src;
   assign done_write = state.done_write;
   assign done_addr  = state.done_addr;
endmodule : cmbc_sched_end

// *** hdl/cmbc_pkg.sv ***
package cmbc_pkg;
   // Timing figures in nanoseconds
   localparam int CLK_NS     = 50;    // Period of mclk
   localparam int MINOR_NS   = 100;   // Minor cycle
   localparam int STEP_NS    = 50;    // Chain shift interval
   localparam int STAGE_NS   = 400;   // Set time of one chain stage
   localparam int CYCLE_NS   = 1000;  // Storage cycle
   localparam int ACCEPT_NS  = 200;   // Issue to accept
   localparam int READ_ON_NS = 255;   // Read on before strobe
   localparam int WRITE_NS   = 355;   // Write drive length
   // Derived cycle counts
   localparam int MINOR_CYC  = MINOR_NS / CLK_NS;
   localparam int STAGE_CYC  = STAGE_NS / STEP_NS;
   localparam int CHAIN_LEN  = (CYCLE_NS - STAGE_NS) / STEP_NS + 1;
   localparam int ACCEPT_CYC = ACCEPT_NS / CLK_NS;
   localparam int WRITE_CYC  = WRITE_NS / CLK_NS;
   // Chain taps
   localparam int TAP_READ   = 0;
   localparam int TAP_MID    = CHAIN_LEN / 2;
   localparam int TAP_LAST   = CHAIN_LEN - 1;
   localparam int TAP_SENSE  = READ_ON_NS / STEP_NS;
   localparam int TAP_MERGE  = TAP_SENSE + 4;
   localparam int TAP_WCLR   = TAP_MERGE + 1;
   localparam int TAP_WLOAD  = TAP_WCLR + 1;
   localparam int TAP_INH    = TAP_LAST - (STAGE_CYC - WRITE_CYC);
   // Address layout
   localparam int ADDR_W      = 17;
   localparam int WADDR_W     = 12;
   localparam int WADDR_LSB   = 5;
   localparam int CHASSIS_W   = 3;
   localparam int CHASSIS_LSB = 2;
   localparam int BANKSEL_W   = 2;
   // Sizes
   localparam int DATA_W     = 60;
   localparam int N_CHASSIS  = 4;
   localparam int BANKS_PER  = 4;
   localparam int N_BANK     = 16;
   localparam int HOPPER_N   = 3;
   localparam int FIFO_DEPTH = 8;
endpackage : cmbc_pkg

// *** hdl/cmbc_link_if.sv ***
`timescale 1ns/10ps
interface cmbc_link_if;
   // Address path
   logic                           go;
   logic                           write;
   logic [cmbc_pkg::ADDR_W-1:0]    addr;
   logic                           accept;
   // Write word path
   logic [cmbc_pkg::DATA_W-1:0]    wdata;
   logic                           wdata_valid;
   logic                           wdata_ready;

   modport sched (output go, write, addr, wdata, wdata_valid,
                  input accept, wdata_ready);
   modport mem (input go, write, addr, wdata, wdata_valid,
                output accept, wdata_ready);
endinterface : cmbc_link_if

// *** hdl/cmbc_memory_end.sv ***
// Functional notes
// - Scheduler issues one address per minor cycle
// - Hopper of three reissues until accepted
// - Every address to a present chassis accepted within 2000 nsec
// - Accept returns 200 nsec after issue
// - Scheduler treats on-time accept as acceptance
// - Busy bank: no accept, address ignored
// - Capture address, pass word address to bank
// - Go decodes five low bits as bank
// - Preset complement code; only match completes
// - Match, free and clock set bank select
// - Chassis accepts ORed into one accept
// - Scheduler drops hopper copy, sends tags
// - Bank go sets read stage, shifts 50ns
// - Each stage set 400ns; gates combine stages
// - Free only when read, mid, last clear
// - Read, sense, merge, inhibit, write in order
// - Bank cycles staggered by a minor cycle
// - Sense strobe placed after read drive on
// - Read drive 400ns, write drive 350ns
// - Read word via temp, buffer, write regs
// - Write word offered all; addressed bank stores
// - Write flag steers restore to write word
// - Write clears restore after merge
`timescale 1ns/10ps
module cmbc_memory_end (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        reset,
   // Link to the scheduler
   cmbc_link_if.mem                         link,
   // Storage module drives, one bit per bank, then word address and restore word per bank
   output logic [cmbc_pkg::N_BANK-1:0]      read_drive,
   output logic [cmbc_pkg::N_BANK-1:0]      sense_strobe,
   output logic [cmbc_pkg::N_BANK-1:0]      start_inhibit,
   output logic [cmbc_pkg::N_BANK-1:0]      end_inhibit,
   output logic [cmbc_pkg::N_BANK-1:0]      bank_merge,
   output logic [cmbc_pkg::N_BANK-1:0]      restore_clear,
   output logic [cmbc_pkg::N_BANK-1:0]      write_drive,
   output logic [cmbc_pkg::N_BANK-1:0][cmbc_pkg::WADDR_W-1:0] bank_addr,
   output logic [cmbc_pkg::N_BANK-1:0][cmbc_pkg::DATA_W-1:0]  restore_word,
   // Sense lines and read word to the distributor
   input  wire logic [cmbc_pkg::DATA_W-1:0] sense_word,
   output logic [cmbc_pkg::DATA_W-1:0]      rd_word,
   output logic                             rd_valid
);
   // Whole state of the memory end
   typedef struct packed {
      logic                                  in_go;       // Input reg
      logic                                  in_write;
      logic [cmbc_pkg::ADDR_W-1:0]           in_addr;
      logic [cmbc_pkg::N_CHASSIS-1:0][cmbc_pkg::CHASSIS_W-1:0] preset;
      logic [cmbc_pkg::N_BANK-1:0]           sel;         // Bank go
      logic [cmbc_pkg::N_CHASSIS-1:0]        chassis_acc; // Per chassis
      logic                                  acc_or;
      logic                                  accept;
      logic [cmbc_pkg::N_BANK-1:0][cmbc_pkg::CHAIN_LEN-1:0] chain;
      logic [cmbc_pkg::N_BANK-1:0]           wr_ref;      // Write ref
      logic [cmbc_pkg::N_BANK-1:0][cmbc_pkg::WADDR_W-1:0] bank_addr;
      logic [cmbc_pkg::N_BANK-1:0]           read_drive;
      logic [cmbc_pkg::N_BANK-1:0]           sense_strobe;
      logic [cmbc_pkg::N_BANK-1:0]           start_inhibit;
      logic [cmbc_pkg::N_BANK-1:0]           end_inhibit;
      logic [cmbc_pkg::N_BANK-1:0]           bank_merge;
      logic [cmbc_pkg::N_BANK-1:0]           restore_clear;
      logic [cmbc_pkg::N_BANK-1:0]           write_drive;
      logic [cmbc_pkg::DATA_W-1:0]           temp;        // Shared path
      logic [cmbc_pkg::DATA_W-1:0]           buffer;
      logic [cmbc_pkg::DATA_W-1:0]           wreg;
      logic                                  rd_valid;
      logic                                  wdata_ready;
      logic [cmbc_pkg::N_BANK-1:0][cmbc_pkg::DATA_W-1:0] restore;
   } cmbc_mem_state_type;

   cmbc_mem_state_type state;       // Registered state
   cmbc_mem_state_type next_state;  // Next value

   // Bank free from read, middle and last stages plus go
   function automatic logic bank_free(
      input logic [cmbc_pkg::CHAIN_LEN-1:0] c,
      input logic                           s
   );
      bank_free = !(s || c[cmbc_pkg::TAP_READ] || c[cmbc_pkg::TAP_MID]
                    || c[cmbc_pkg::TAP_LAST]);
   endfunction : bank_free

   // One-cycle gate from a set stage and the cleared next stage
   function automatic logic stage_edge(
      input logic [cmbc_pkg::CHAIN_LEN-1:0] c,
      input int                             k
   );
      stage_edge = c[k] && !c[k+1];
   endfunction : stage_edge

   // Next state of decode, chains and restore path
   always_comb begin : comb_proc
      logic hit;
      logic match;
      int   b;
      hit   = 1'b0;
      match = 1'b0;
      b     = 0;
      next_state = state;
      // Input register takes every address
      next_state.in_go    = link.go;
      next_state.in_write = link.write;
      next_state.in_addr  = link.addr;
      // Accept OR and delay to the 200 ns point
      next_state.acc_or      = |state.chassis_acc;
      next_state.accept      = state.acc_or;
      next_state.chassis_acc = '0;
      // Shared read path: temp, buffer, write register
      next_state.rd_valid = |state.sense_strobe;
      if (|state.sense_strobe) begin
         next_state.temp = sense_word;
      end
      next_state.buffer      = state.temp;
      next_state.wreg        = state.buffer;
      next_state.wdata_ready = 1'b0;
      for (int ch = 0; ch < cmbc_pkg::N_CHASSIS; ch++) begin
         // Clock pulse presets the complement of own code
         next_state.preset[ch] = ~cmbc_pkg::CHASSIS_W'(ch);
         match = state.in_go && ((state.in_addr[cmbc_pkg::CHASSIS_LSB +:
                 cmbc_pkg::CHASSIS_W] ^ state.preset[ch])
                 == '1);
         for (int bk = 0; bk < cmbc_pkg::BANKS_PER; bk++) begin
            b = ch * cmbc_pkg::BANKS_PER + bk;
            // Busy bank ignores the address entirely
            hit = match
               && (state.in_addr[cmbc_pkg::BANKSEL_W-1:0]
                   == cmbc_pkg::BANKSEL_W'(bk))
               && bank_free(state.chain[b], state.sel[b]);
            next_state.sel[b] = hit;
            if (hit) begin
               // Bank busy at most one storage cycle bounds reissue
               next_state.chassis_acc[ch] = 1'b1;
               next_state.wr_ref[b]       = state.in_write;
               next_state.bank_addr[b]    = state.in_addr[
                  cmbc_pkg::WADDR_LSB +: cmbc_pkg::WADDR_W];
            end
         end
      end
      for (int i = 0; i < cmbc_pkg::N_BANK; i++) begin
         // Chain: go sets read stage, held for a full stage time
         next_state.chain[i][0] = state.sel[i] || (state.chain[i][0]
            && !state.chain[i][cmbc_pkg::STAGE_CYC-1]);
         next_state.chain[i][cmbc_pkg::CHAIN_LEN-1:1] =
            state.chain[i][cmbc_pkg::CHAIN_LEN-2:0];
         // Drive signals in their cycle order
         next_state.read_drive[i] =
            state.chain[i][cmbc_pkg::TAP_READ];
         next_state.sense_strobe[i] =
            stage_edge(state.chain[i], cmbc_pkg::TAP_SENSE);
         next_state.bank_merge[i] =
            stage_edge(state.chain[i], cmbc_pkg::TAP_MERGE);
         next_state.restore_clear[i] = state.wr_ref[i]
            && stage_edge(state.chain[i], cmbc_pkg::TAP_WCLR);
         next_state.start_inhibit[i] =
            stage_edge(state.chain[i], cmbc_pkg::TAP_INH);
         next_state.end_inhibit[i] = state.chain[i][cmbc_pkg::TAP_LAST]
            && !state.chain[i][cmbc_pkg::TAP_INH];
         next_state.write_drive[i] = state.chain[i][cmbc_pkg::TAP_LAST]
            && state.chain[i][cmbc_pkg::TAP_INH];
         // Restore register of this bank
         if (stage_edge(state.chain[i], cmbc_pkg::TAP_MERGE)) begin
            next_state.restore[i] = state.wreg;
         end
         if (state.wr_ref[i]
             && stage_edge(state.chain[i], cmbc_pkg::TAP_WCLR)) begin
            next_state.restore[i]  = '0;
            next_state.wdata_ready = 1'b1;
         end
         // Only the bank at its load point takes the write word
         if (state.wr_ref[i] && state.wdata_ready && link.wdata_valid
             && stage_edge(state.chain[i], cmbc_pkg::TAP_WLOAD)) begin
            next_state.restore[i] = link.wdata;
         end
      end
   end

   // State register with synchronous reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign link.accept      = state.accept;
   assign link.wdata_ready = state.wdata_ready;
   assign read_drive       = state.read_drive;
   assign sense_strobe     = state.sense_strobe;
   assign start_inhibit    = state.start_inhibit;
   assign end_inhibit      = state.end_inhibit;
   assign bank_merge       = state.bank_merge;
   assign restore_clear    = state.restore_clear;
   assign write_drive      = state.write_drive;
   assign bank_addr        = state.bank_addr;
   assign restore_word     = state.restore;
   assign rd_word          = state.temp;
   assign rd_valid         = state.rd_valid;
endmodule : cmbc_memory_end

// *** sim/cmbc_link_sva.sv ***
`timescale 1ns/10ps
module cmbc_link_sva (
   // Clock, reset and link
   input wire logic                      mclk,
   input wire logic                      reset,
   input wire logic                      go,
   input wire logic                      write,
   input wire logic [cmbc_pkg::ADDR_W-1:0] addr,
   input wire logic                      accept,
   input wire logic                      wdata_valid,
   input wire logic                      wdata_ready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [4:0] acc_bank;  // Bank of last accept
   logic [4:0] busy_cnt;  // Guard cycles left
   // Remember the bank that was last accepted
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_cnt <= 5'h00;
      end else if (accept) begin
         busy_cnt <= 5'h0e;
         acc_bank <= $past(addr[4:0], 4);
      end else if (busy_cnt != 5'h00) begin
         busy_cnt <= busy_cnt - 5'h01;
      end
   end
   // A write reference being accepted
   sequence s_wr_acc;
      accept && $past(write, 4);
   endsequence
   a_go_spacing: assert property (go |=> !go)
      else $error("go in adjacent cycles");
   a_accept_delay: assert property (accept |-> $past(go, 4))
      else $error("accept not four cycles after go");
   a_accept_once: assert property (accept |=> !accept)
      else $error("accept longer than one cycle");
   a_chassis_match: assert property (accept |-> !$past(addr[4], 4))
      else $error("accept for absent chassis");
   a_busy_refuse: assert property
      (go && busy_cnt != 5'h00 && addr[4:0] == acc_bank |-> ##4 !accept)
      else $error("busy bank accepted");
   a_accept_bound: assert property
      (go && !addr[4] |-> ##[4:40] accept)
      else $error("address not accepted in time");
   a_write_pop: assert property (s_wr_acc |-> ##10 wdata_ready)
      else $error("write word not taken");
   a_read_nopop: assert property
      (accept && !$past(write, 4) |-> ##10 !wdata_ready)
      else $error("read took a write word");
   a_wdata_push: assert property (s_wr_acc |-> ##[1:2] wdata_valid)
      else $error("write word not queued");
   a_reset_idle: assert property ($fell(reset) |-> !accept ##1 !accept)
      else $error("accept right after reset");
endmodule : cmbc_link_sva

// *** sim/test_core_memory_bank_control.sv ***
`timescale 1ns/10ps
module test_core_memory_bank_control;
   localparam int AW = cmbc_pkg::ADDR_W;
   localparam int DW = cmbc_pkg::DATA_W;
   localparam int NB = cmbc_pkg::N_BANK;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] req_valid = '0;
   logic [1:0] req_write = '0;
   logic [1:0] req_ready;
   logic [1:0][AW-1:0] req_addr = '0;
   logic [1:0][DW-1:0] req_data = '0;
   logic done_valid;
   logic [0:0] done_src;
   logic [AW-1:0] done_addr;
   logic [NB-1:0] rdrv;
   logic [NB-1:0] wdrv;
   logic [NB-1:0] rclr;
   int wd_len = 0, wd_max = 0, n_clr = 0;
   logic [NB-1:0][11:0] bank_addr;
   logic [NB-1:0][DW-1:0] restore_word;
   logic [DW-1:0] sense_word = 60'h0a5c3e9d1f2b467;
   logic [DW-1:0] rd_word, rd_seen;
   logic rd_valid;
   int num_errors = 0, n_tests = 0, cycles = 0, drv_len = 0, drv_max = 0;
   logic [AW-1:0] done_q[$];
   int done_t[$];
   cmbc_link_if cmbc_link_if_i ();
   cmbc_sched_end #(.N_REQ(2)) cmbc_sched_end_i (.mclk(mclk), .reset(reset),
      .link(cmbc_link_if_i), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .done_valid(done_valid), .done_src(done_src), .done_write(),
      .done_addr(done_addr));
   cmbc_memory_end cmbc_memory_end_i (.mclk(mclk), .reset(reset),
      .link(cmbc_link_if_i), .read_drive(rdrv), .sense_strobe(),
      .start_inhibit(), .end_inhibit(), .bank_merge(), .restore_clear(rclr),
      .write_drive(wdrv), .bank_addr(bank_addr), .restore_word(restore_word),
      .sense_word(sense_word), .rd_word(rd_word), .rd_valid(rd_valid));
   cmbc_link_sva cmbc_link_sva_i (.mclk(mclk), .reset(reset),
      .go(cmbc_link_if_i.go), .write(cmbc_link_if_i.write),
      .addr(cmbc_link_if_i.addr), .accept(cmbc_link_if_i.accept),
      .wdata_valid(cmbc_link_if_i.wdata_valid),
      .wdata_ready(cmbc_link_if_i.wdata_ready));
   always #25 mclk = ~mclk;
   // Record tags, read words, read drive length and the timeout
   always @(posedge mclk) begin
      cycles++;
      if (done_valid === 1'b1) begin
         done_q.push_back(done_addr);
         done_t.push_back(cycles);
      end
      if (rd_valid === 1'b1) rd_seen = rd_word;
      drv_len = (rdrv[0] === 1'b1) ? drv_len + 1 : 0;
      if (drv_len > drv_max) drv_max = drv_len;
      // Write drive length of bank 1 and restore clear pulses
      wd_len = (wdrv[1] === 1'b1) ? wd_len + 1 : 0;
      if (wd_len > wd_max) wd_max = wd_len;
      if ((|rclr) === 1'b1) n_clr++;
      if (cycles == 1000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask : tick
   task automatic check(input string what, input logic [63:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Hold a request until its ready pulse is seen
   task automatic issue(input int i, input logic w, input logic [AW-1:0] a,
                        input logic [DW-1:0] d);
      int n;
      n = 0;
      req_valid[i] = 1'b1;
      req_write[i] = w;
      req_addr[i] = a;
      req_data[i] = d;
      do begin
         @(posedge mclk);
         n++;
      end while (req_ready[i] !== 1'b1 && n < 200);
      #5;
      req_valid[i] = 1'b0;
   endtask : issue
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   // Read, write, then two references to one bank
   initial begin
      tick(3);
      reset = 1'b0;
      tick(1);
      issue(0, 1'b0, {12'h005, 5'h00}, '0);
      tick(30);
      check("read word", rd_seen, sense_word);
      check("read drive", drv_max, cmbc_pkg::STAGE_CYC);
      check("word address", bank_addr[0], 12'h005);
      issue(1, 1'b1, {12'h0a3, 5'h01}, 60'h0123456789abcde);
      tick(30);
      check("restore word", restore_word[1], 60'h0123456789abcde);
      check("write drive", wd_max, cmbc_pkg::WRITE_CYC);
      fork
         issue(0, 1'b0, {12'h011, 5'h02}, '0);
         issue(1, 1'b1, {12'h022, 5'h02}, 60'h0fedcba98765432);
      join
      tick(60);
      check("accepts", done_q.size(), 4);
      check("priority", done_q[2], {12'h011, 5'h02});
      check("busy gap", done_t[3] - done_t[2] >= 16, 1);
      check("worst wait", done_t[3] - done_t[2] <= 40, 1);
      check("bank 2 word", restore_word[2], 60'h0fedcba98765432);
      check("restore clears", n_clr, 2);
      give_verdict();
   end
endmodule : test_core_memory_bank_control
